// ---- src/eisf_pkg.sv ----
// Package of constants and carriers for the external interrupt sense and flag block
package eisf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned EISF_CHANNELS = 6;
  localparam int unsigned EISF_REG_W = 8;
  localparam int unsigned EISF_ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [EISF_ADDR_W-1:0] EISF_IDX_SENSE = 12'h0F4;
  localparam logic [EISF_ADDR_W-1:0] EISF_IDX_ENABLE = 12'h0F5;
  localparam logic [EISF_ADDR_W-1:0] EISF_IDX_FLAGS = 12'h0F6;
  localparam logic [EISF_ADDR_W-1:0] EISF_ADDR_SENSE = EISF_IDX_SENSE << 2;
  localparam logic [EISF_ADDR_W-1:0] EISF_ADDR_ENABLE = EISF_IDX_ENABLE << 2;
  localparam logic [EISF_ADDR_W-1:0] EISF_ADDR_FLAGS = EISF_IDX_FLAGS << 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [EISF_REG_W-1:0] EISF_RST_SENSE = 8'h00;
  localparam logic [EISF_REG_W-1:0] EISF_RST_ENABLE = 8'h00;
  localparam logic [EISF_REG_W-1:0] EISF_RST_FLAGS = 8'h00;

  // ----------------------------------------------------------------
  // Sense modes
  // ----------------------------------------------------------------
  typedef enum logic
  {
    EISF_SENSE_LEVEL = 1'b0,
    EISF_SENSE_FALL = 1'b1
  } eisf_sense_e;

  // ----------------------------------------------------------------
  // APB carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [EISF_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } eisf_apb_req_s;

  typedef struct packed
  {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eisf_apb_rsp_s;

endpackage : eisf_pkg

// ---- src/eisf_channel.sv ----
// One channel: pin synchroniser, sense logic and sticky request flag
`timescale 1ns/1ps
module eisf_channel
  import eisf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_n,
  input wire logic sense_fall,
  input wire logic enable,
  input wire logic ack,
  input wire logic armed_clear,
  output logic flag,
  output logic req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic prev;
    logic flag;
  } eisf_ch_s;

  eisf_ch_s st_q;
  eisf_ch_s st_d;
  logic set_ev;
  logic clr_ev;

  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = pin_n;
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;
    set_ev = 1'b0;
    clr_ev = armed_clear;
    if (eisf_sense_e'(sense_fall) == EISF_SENSE_LEVEL)
    begin
      set_ev = !st_q.sync2;
      // Level clear only once the pin has let go
      if (ack && st_q.sync2)
        clr_ev = 1'b1;
    end
    else
    begin
      set_ev = st_q.prev && !st_q.sync2;
      if (ack)
        clr_ev = 1'b1;
    end
    // Set beats clear so no event is lost
    if (set_ev)
      st_d.flag = 1'b1;
    else if (clr_ev)
      st_d.flag = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, flag: 1'b0};
    else
      st_q <= st_d;
  end

  assign flag = st_q.flag;
  assign req = st_q.flag && enable;

endmodule : eisf_channel

// ---- src/eisf_top.sv ----
// External interrupt request sensing, enables and pending flags over APB
// Operation
// - With sense-select 0 a low level on the request pin is an interrupt request.
// - With sense-select 1 only a falling edge on the request pin raises a request.
// - A channel's enable bit at 1 lets its request through, at 0 blocks it.
// - In level sense the flag is set whenever the pin is low.
// - In edge sense the flag is set when a falling edge is seen on the pin.
// - Software clears a flag by reading it as 1 and then writing 0 to it.
// - In level sense the flag clears on exception handling while the pin is high.
// - In edge sense the flag clears on exception handling for that channel.
// - Flag bits accept a written 0 only to clear and a written 1 never sets them.
`timescale 1ns/1ps
module eisf_top
  import eisf_pkg::*;
#(
  parameter int unsigned CHANNELS = EISF_CHANNELS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire eisf_pkg::eisf_apb_req_s apb_req,
  output eisf_pkg::eisf_apb_rsp_s apb_rsp,
  input wire logic [CHANNELS-1:0] ext_request_pin_n,
  input wire logic [CHANNELS-1:0] exc_ack,
  output logic [CHANNELS-1:0] cpu_irq_req
);
  import eisf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [EISF_REG_W-1:0] sense;
    logic [EISF_REG_W-1:0] enable;
    logic [CHANNELS-1:0] armed;
    logic rdphase;
    logic [31:0] prdata;
  } eisf_top_s;

  eisf_top_s st_q;
  eisf_top_s st_d;
  logic [CHANNELS-1:0] flags;
  logic [CHANNELS-1:0] armed_clear;
  logic [EISF_REG_W-1:0] flags_rd;
  logic access;
  logic wr;
  logic rd;
  logic hit_sense;
  logic hit_enable;
  logic hit_flags;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Writes complete in their first access cycle; reads add one wait state
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite;
  assign rd = access && !apb_req.pwrite;
  assign hit_sense = apb_req.paddr == EISF_ADDR_SENSE;
  assign hit_enable = apb_req.paddr == EISF_ADDR_ENABLE;
  assign hit_flags = apb_req.paddr == EISF_ADDR_FLAGS;
  assign flags_rd = EISF_REG_W'(flags);

  always_comb
  begin
    st_d = st_q;
    armed_clear = '0;
    // Marks the second access cycle of a read, the one that completes
    st_d.rdphase = rd && !st_q.rdphase;
    if (wr && hit_sense)
      st_d.sense = apb_req.pwdata[EISF_REG_W-1:0];
    if (wr && hit_enable)
      st_d.enable = apb_req.pwdata[EISF_REG_W-1:0];
    if (wr && hit_flags)
    begin
      // Only a written 0 over an armed bit clears; a 1 is ignored
      armed_clear = st_q.armed & ~apb_req.pwdata[CHANNELS-1:0];
      st_d.armed = '0;
    end
    if (rd && hit_flags)
      st_d.armed = st_q.armed | flags;
    // Drop arming for flags that hardware has already cleared
    st_d.armed = st_d.armed & flags;
    if (rd)
    begin
      st_d.prdata = '0;
      if (hit_sense)
        st_d.prdata[EISF_REG_W-1:0] = st_q.sense;
      else if (hit_enable)
        st_d.prdata[EISF_REG_W-1:0] = st_q.enable;
      else if (hit_flags)
        st_d.prdata[EISF_REG_W-1:0] = flags_rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{sense: EISF_RST_SENSE, enable: EISF_RST_ENABLE, armed: '0,
        rdphase: 1'b0, prdata: '0};
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_ch
    eisf_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .pin_n(ext_request_pin_n[i]),
      .sense_fall(st_q.sense[i]),
      .enable(st_q.enable[i]),
      .ack(exc_ack[i]),
      .armed_clear(armed_clear[i]),
      .flag(flags[i]),
      .req(cpu_irq_req[i])
    );
  end

  // Read data is registered, so a read's prdata is valid one cycle later;
  // pready is held low in the first access cycle of a read to line it up.
  assign apb_rsp = '{pready: !rd || st_q.rdphase, pslverr: 1'b0, prdata: st_q.prdata};

endmodule : eisf_top

// ---- verification/eisf_sva.sv ----
// Checker of bus timing and request flag behaviour
`timescale 1ns/1ps
module eisf_sva
  import eisf_pkg::*;
#(
  parameter int unsigned CHANNELS = EISF_CHANNELS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire eisf_pkg::eisf_apb_req_s apb_req,
  input wire eisf_pkg::eisf_apb_rsp_s apb_rsp,
  input wire logic [CHANNELS-1:0] ext_request_pin_n,
  input wire logic [CHANNELS-1:0] exc_ack,
  input wire logic [CHANNELS-1:0] cpu_irq_req
);
  // Pin history: five quiet samples mean no edge still in the synchroniser
  logic [CHANNELS-1:0] p1_q, p2_q, p3_q, p4_q;
  wire [CHANNELS-1:0] hi = ext_request_pin_n & p1_q & p2_q & p3_q & p4_q;
  wire rd = apb_req.psel && !apb_req.pwrite;
  always_ff @(posedge pclk)
  begin
    p1_q <= ext_request_pin_n;
    p2_q <= p1_q;
    p3_q <= p2_q;
    p4_q <= p3_q;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_slverr; !apb_rsp.pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("slave error raised");
  property p_wready; apb_req.psel && apb_req.penable && apb_req.pwrite |-> apb_rsp.pready;
  endproperty
  a_wready: assert property (p_wready) else $error("write not ready at once");
  property p_rwait; rd && $rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready;
  endproperty
  a_rwait: assert property (p_rwait) else $error("read wait state wrong");
  property p_upper; rd && apb_req.penable && apb_rsp.pready |-> apb_rsp.prdata[31:8] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_prdata; !rd |=> $stable(apb_rsp.prdata); endproperty
  a_prdata: assert property (p_prdata) else $error("read data moved");
  property p_rst; $rose(presetn) |-> cpu_irq_req == '0; endproperty
  a_rst: assert property (p_rst) else $error("request after reset");
  property p_ack; |(exc_ack & hi) |=> (cpu_irq_req & $past(exc_ack & hi)) == '0; endproperty
  a_ack: assert property (p_ack) else $error("flag kept after acknowledge");
  property p_quiet; &hi && !$past(apb_req.psel) && !$past(|exc_ack) |-> $stable(cpu_irq_req);
  endproperty
  a_quiet: assert property (p_quiet) else $error("request moved on quiet pins");
endmodule : eisf_sva

// ---- verification/eisf_pin_model.sv ----
// Far-side model: request pins and exception acknowledge
`timescale 1ns/1ps
module eisf_pin_model
(
  input wire logic [5:0] lvl,
  input wire logic [5:0] ack_go,
  output logic [5:0] pin_n,
  output logic [5:0] ack
);
  // Pins are asynchronous, so they move off the clock edge
  assign #3 pin_n = lvl;
  assign ack = ack_go;
endmodule : eisf_pin_model

// ---- verification/eisf_tb_top.sv ----
// Testbench: register access, sensing, clearing and acknowledge
`timescale 1ns/1ps
module eisf_tb_top;
  import eisf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  eisf_apb_req_s req = '0;
  eisf_apb_rsp_s rsp;
  logic [5:0] lvl = '1, ack_go = '0, pin_n, ack, irq;
  logic [31:0] rd;
  int n_mismatch = 0, compares = 0;
  always #5 pclk = ~pclk;
  eisf_top #(.CHANNELS(6)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_request_pin_n(pin_n), .exc_ack(ack), .cpu_irq_req(irq));
  eisf_pin_model pm (.lvl(lvl), .ack_go(ack_go), .pin_n(pin_n), .ack(ack));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    rd = rsp.prdata;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rchk
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("sense", EISF_ADDR_SENSE, 32'h0);
    rchk("enable", EISF_ADDR_ENABLE, 32'h0);
    apb(1'b1, 12'h000, 32'hFF);
    rchk("unmapped", 12'h000, 32'h0);
    apb(1'b1, EISF_ADDR_FLAGS, 32'hFF);
    rchk("flags_w1", EISF_ADDR_FLAGS, 32'h0);
    // Channels 0 to 2 level, 3 to 5 edge; bits 7:6 plain storage
    apb(1'b1, EISF_ADDR_SENSE, 32'hF8);
    rchk("sense_rw", EISF_ADDR_SENSE, 32'hF8);
    apb(1'b1, EISF_ADDR_ENABLE, 32'h3F);
    lvl <= 6'h36;
    repeat (6) @(posedge pclk);
    chk("req_set", 32'(irq), 32'h09);
    apb(1'b1, EISF_ADDR_ENABLE, 32'h36);
    chk("req_masked", 32'(irq), 32'h0);
    apb(1'b1, EISF_ADDR_ENABLE, 32'h3F);
    apb(1'b1, EISF_ADDR_FLAGS, 32'h0);
    rchk("flags_noarm", EISF_ADDR_FLAGS, 32'h09);
    apb(1'b1, EISF_ADDR_FLAGS, 32'h0);
    // Held-low edge channel must not set again; level channel does
    rchk("flags_armed", EISF_ADDR_FLAGS, 32'h01);
    lvl <= 6'h3F;
    @(posedge pclk);
    lvl <= 6'h35;
    repeat (6) @(posedge pclk);
    // Channel 1 stays low: level flag must survive its acknowledge
    lvl <= 6'h35;
    repeat (6) @(posedge pclk);
    ack_go <= 6'h0B;
    @(posedge pclk);
    ack_go <= 6'h0;
    repeat (2) @(posedge pclk);
    chk("req_ack", 32'(irq), 32'h02);
    lvl <= 6'h3F;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("req_rst", 32'(irq), 32'h0);
    rchk("enable_rst", EISF_ADDR_ENABLE, 32'h0);
    report_and_stop();
  end
  // Hang guard, well beyond the roughly 90 cycles used
  initial
  begin
    #20us;
    n_mismatch++;
    report_and_stop();
  end
endmodule : eisf_tb_top
bind eisf_top eisf_sva #(.CHANNELS(CHANNELS)) u_sva (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_request_pin_n(ext_request_pin_n),
  .exc_ack(exc_ack), .cpu_irq_req(cpu_irq_req));
